// *** rtl/itdt_cfg.svh ***
`ifndef ITDT_CFG_SVH
`define ITDT_CFG_SVH

// ==========================================================
// Timing counts at the 25 MHz system clock.
`define ITDT_CLK_NS      40
`define ITDT_TICK_NS     5333
`define ITDT_TICK_CYC    (`ITDT_TICK_NS / `ITDT_CLK_NS)
`define ITDT_P100_LONG   5'd19
`define ITDT_P100_SHORT  5'd18
`define ITDT_D12_CNT     4'd12
`define ITDT_UP_400US    6'd4
`define ITDT_UP_800US    6'd8
`define ITDT_UP_1MS      6'd10
`define ITDT_UP_2MS      6'd20
`define ITDT_UP_5MS      6'd50

// ==========================================================
// Register offsets.
`define ITDT_IVL_ADDR    8'h9c
`define ITDT_SYSTEM_CLOCK_GENERATOR_REG_ADDR 8'h8e
`define ITDT_CLKSEL_ADDR 8'hc9
`define ITDT_TMR0_BASE   8'ha0
`define ITDT_TMR1_BASE   8'ha8
`define ITDT_T_CTRL      3'd0
`define ITDT_T_CNTL      3'd1
`define ITDT_T_CNTH      3'd2
`define ITDT_T_RLDL      3'd3
`define ITDT_T_RLDH      3'd4

// ==========================================================
// Field positions.
`define ITDT_IVL_FLAG    7
`define ITDT_IVL_EN      6
`define ITDT_IVL_CLR     5
`define ITDT_SYS_TCLR    3
`define ITDT_T_FLAGH     7
`define ITDT_T_FLAGL     6
`define ITDT_T_LEN       5
`define ITDT_T_SPLIT     4
`define ITDT_T_CAPH      3
`define ITDT_T_CAPL      2
`define ITDT_T_RUNH      1
`define ITDT_T_RUNL      0
`define ITDT_RST_VAL     8'h00

`endif

// *** rtl/itdt_pkg.sv ***
package itdt_pkg;

  // ==========================================================
  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } itdt_bus_t;

  // ==========================================================
  // One timer: count, reload/capture bytes and control bits.
  typedef struct packed {
    logic [7:0] cnt_l;
    logic [7:0] cnt_h;
    logic [7:0] rld_l;
    logic [7:0] rld_h;
    logic       flag_h;
    logic       flag_l;
    logic       flag_l_en;
    logic       split;
    logic       cap_h;
    logic       cap_l;
    logic       run_h;
    logic       run_l;
  } itdt_tmr_t;

  // ==========================================================
  // Whole block state.
  typedef struct packed {
    logic [7:0]      tick_cnt;
    logic [4:0]      lo_cnt;
    logic [1:0]      phase;
    logic [5:0]      up_cnt;
    logic            ivl_flag;
    logic            ivl_en;
    logic [2:0]      ivl_sel;
    logic [2:0]      sys_div;
    logic [6:0]      pre_cnt;
    logic [3:0]      d12_cnt;
    logic [7:0]      clksel;
    itdt_tmr_t [1:0] tmr;
    logic [7:0]      rdata;
    logic [1:0]      irq;
  } itdt_state_t;

endpackage

// *** rtl/itdt_top.sv ***
// What this block does
// - Interval flag set by hardware, cleared by software only.
// - Enable resumes tick and pulse stages from held counts.
// - Interval clear resets pulse generator, not tick.
// - Reserved interval control bits read zero.
// - Selection decodes none, 100us..5ms with fractional divides.
// - Two identical timers, separate capture events.
// - Count held as low and high byte.
// - Wide mode: one 16-bit counter, low controls.
// - Split mode: two independent 8-bit counters.
// - Reload mode counts up, flags, reloads on overflow.
// - Capture mode wraps freely, latches count, flags.
// - Four selectable count sources per half.
// - System source is clock divided by 2^N.
// - All sources synchronous, used as count enables.
// - Split halves combine modes freely, share capture.
// - Interrupt is high flag or enabled low flag.
// - Wide reload: high flag on high, low on low.
// - Wide capture: high flag on capture, low on wrap.
// - Base tick constant, independent of system divider.
// - Tick generator clear bit resets base tick counter.
// - Wide overflow loads 16-bit reload value.
// - Capture latches count into reload registers.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "itdt_cfg.svh"

module itdt_top (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Register port.
  input  wire itdt_pkg::itdt_bus_t bus_i,
  output logic [7:0]               rdata_o,
  // Capture events, one-cycle pulses from the edge logic.
  input  wire logic [1:0]          cap_ev_i,
  // Requests.
  output logic [1:0]               tmr_irq_o,
  output logic                     ivl_flag_o
);
  import itdt_pkg::*;

  itdt_state_t q;
  itdt_state_t d;
  logic        tick_stb;
  logic        p100_stb;
  logic        sys_stb;
  logic        d12_stb;
  logic        ivl_set;
  logic [1:0]  ovh;
  logic        wr_ivl;
  logic        wr_sys;
  logic        wr_clk;

  // ==========================================================
  // Write decode.
  assign wr_ivl = bus_i.we && (bus_i.addr == `ITDT_IVL_ADDR);
  assign wr_sys = bus_i.we && (bus_i.addr == `ITDT_SYSTEM_CLOCK_GENERATOR_REG_ADDR);
  assign wr_clk = bus_i.we && (bus_i.addr == `ITDT_CLKSEL_ADDR);

  // One half of a split timer: returns next count, reload and flag set.
  function automatic logic [16:0] half_step(input logic [7:0] cnt, input logic [7:0] rld,
                                            input logic inc, input logic cap, input logic ev);
    logic [7:0] cn;
    logic [7:0] rn;
    logic       s;
    cn = cnt;
    rn = rld;
    s  = 1'b0;
    if (cap) begin
      if (inc) begin
        cn = cnt + 8'd1;
      end
      if (ev) begin
        rn = cnt;
        s  = 1'b1;
      end
    end else if (inc) begin
      if (cnt == 8'hff) begin
        cn = rld;
        s  = 1'b1;
      end else begin
        cn = cnt + 8'd1;
      end
    end
    return {cn, rn, s};
  endfunction

  // ==========================================================
  // Next-state logic for the whole block.
  always_comb begin
    logic [6:0]  div_mask;
    logic [4:0]  lo_tgt;
    logic [5:0]  up_tgt;
    logic [3:0]  src;
    logic [7:0]  base;
    logic        hit;
    logic        inc_l;
    logic        inc_h;
    logic        set_h;
    logic        set_l;
    logic [15:0] c16;
    logic [16:0] hs;
    div_mask = 7'h00;
    lo_tgt   = 5'd0;
    up_tgt   = 6'd0;
    src      = 4'h0;
    base     = 8'h00;
    hit      = 1'b0;
    inc_l    = 1'b0;
    inc_h    = 1'b0;
    set_h    = 1'b0;
    set_l    = 1'b0;
    c16      = 16'h0000;
    hs       = 17'h00000;
    d        = q;
    tick_stb = 1'b0;
    p100_stb = 1'b0;
    d12_stb  = 1'b0;
    ivl_set  = 1'b0;
    ovh      = 2'b00;

    // System source prescaler; one strobe every 2^N cycles.
    d.pre_cnt = q.pre_cnt + 7'd1;
    div_mask  = ~(7'h7f << q.sys_div);
    sys_stb   = ((q.pre_cnt & div_mask) == div_mask);
    if (sys_stb) begin
      if (q.d12_cnt == `ITDT_D12_CNT - 4'd1) begin
        d.d12_cnt = 4'd0;
        d12_stb   = 1'b1;
      end else begin
        d.d12_cnt = q.d12_cnt + 4'd1;
      end
    end

    // Base tick runs off the undivided clock so the divider never skews it.
    if (wr_sys && bus_i.wdata[`ITDT_SYS_TCLR]) begin
      d.tick_cnt = 8'd0;
    end else if (q.ivl_en) begin
      if (q.tick_cnt == 8'(`ITDT_TICK_CYC - 1)) begin
        d.tick_cnt = 8'd0;
        tick_stb   = 1'b1;
      end else begin
        d.tick_cnt = q.tick_cnt + 8'd1;
      end
    end

    // Lower stage: 19/19/19/18 ticks; pairs of it give the 38/37 train.
    lo_tgt = (q.phase == 2'd3) ? `ITDT_P100_SHORT : `ITDT_P100_LONG;
    case (q.ivl_sel)
      3'd3:    up_tgt = `ITDT_UP_400US;
      3'd4:    up_tgt = `ITDT_UP_800US;
      3'd5:    up_tgt = `ITDT_UP_1MS;
      3'd6:    up_tgt = `ITDT_UP_2MS;
      default: up_tgt = `ITDT_UP_5MS;
    endcase
    if (wr_ivl && bus_i.wdata[`ITDT_IVL_CLR]) begin
      d.lo_cnt = 5'd0;
      d.phase  = 2'd0;
      d.up_cnt = 6'd0;
    end else if (tick_stb) begin
      if (q.lo_cnt == lo_tgt - 5'd1) begin
        d.lo_cnt = 5'd0;
        d.phase  = q.phase + 2'd1;
        p100_stb = 1'b1;
      end else begin
        d.lo_cnt = q.lo_cnt + 5'd1;
      end
      // Upper stage counts only for the longer intervals.
      if (p100_stb) begin
        case (q.ivl_sel)
          3'd0: ivl_set = 1'b0;
          3'd1: ivl_set = 1'b1;
          3'd2: ivl_set = q.phase[0];
          default: begin
            if (q.up_cnt >= up_tgt - 6'd1) begin
              d.up_cnt = 6'd0;
              ivl_set  = 1'b1;
            end else begin
              d.up_cnt = q.up_cnt + 6'd1;
            end
          end
        endcase
      end
    end

    // Interval control register; reserved bits hold no state.
    if (wr_ivl) begin
      d.ivl_en  = bus_i.wdata[`ITDT_IVL_EN];
      d.ivl_sel = bus_i.wdata[2:0];
      if (!bus_i.wdata[`ITDT_IVL_FLAG]) begin
        d.ivl_flag = 1'b0;
      end
    end
    d.ivl_flag = d.ivl_flag | ivl_set;
    if (wr_sys) begin
      d.sys_div = bus_i.wdata[2:0];
    end
    if (wr_clk) begin
      d.clksel = bus_i.wdata;
    end

    // Sources as strobes, indexed by the two-bit select code.
    src = {p100_stb, tick_stb, d12_stb, sys_stb};

    // Both timers share one description; only the base address, the source select field and the capture input differ.
    for (int t = 0; t < 2; t++) begin
      base  = (t == 0) ? `ITDT_TMR0_BASE : `ITDT_TMR1_BASE;
      hit   = bus_i.we && (bus_i.addr[7:3] == base[7:3]);
      inc_l = q.tmr[t].run_l && src[q.clksel[4*t +: 2]];
      inc_h = q.tmr[t].run_h && src[q.clksel[4*t+2 +: 2]];
      c16   = {q.tmr[t].cnt_h, q.tmr[t].cnt_l};
      set_h = 1'b0;
      set_l = 1'b0;
      if (!q.tmr[t].split) begin
        ovh[t] = inc_l && (c16 == 16'hffff);
        if (q.tmr[t].cap_l) begin
          if (inc_l) begin
            {d.tmr[t].cnt_h, d.tmr[t].cnt_l} = c16 + 16'd1;
          end
          if (cap_ev_i[t]) begin
            {d.tmr[t].rld_h, d.tmr[t].rld_l} = c16;
            set_h = 1'b1;
          end
          set_l = ovh[t];
        end else if (inc_l) begin
          {d.tmr[t].cnt_h, d.tmr[t].cnt_l} = ovh[t] ? {q.tmr[t].rld_h, q.tmr[t].rld_l} : c16 + 16'd1;
          set_h = ovh[t];
          set_l = (q.tmr[t].cnt_l == 8'hff);
        end
      end else begin
        hs = half_step(q.tmr[t].cnt_l, q.tmr[t].rld_l, inc_l, q.tmr[t].cap_l, cap_ev_i[t]);
        {d.tmr[t].cnt_l, d.tmr[t].rld_l, set_l} = hs;
        hs = half_step(q.tmr[t].cnt_h, q.tmr[t].rld_h, inc_h, q.tmr[t].cap_h, cap_ev_i[t]);
        {d.tmr[t].cnt_h, d.tmr[t].rld_h, set_h} = hs;
      end
      // Software writes to data bytes override the counter in that cycle.
      if (hit) begin
        case (bus_i.addr[2:0])
          `ITDT_T_CTRL: begin
            if (!bus_i.wdata[`ITDT_T_FLAGH]) begin
              d.tmr[t].flag_h = 1'b0;
            end
            if (!bus_i.wdata[`ITDT_T_FLAGL]) begin
              d.tmr[t].flag_l = 1'b0;
            end
            d.tmr[t].flag_l_en = bus_i.wdata[`ITDT_T_LEN];
            d.tmr[t].split     = bus_i.wdata[`ITDT_T_SPLIT];
            d.tmr[t].cap_h     = bus_i.wdata[`ITDT_T_CAPH];
            d.tmr[t].cap_l     = bus_i.wdata[`ITDT_T_CAPL];
            d.tmr[t].run_h     = bus_i.wdata[`ITDT_T_RUNH];
            d.tmr[t].run_l     = bus_i.wdata[`ITDT_T_RUNL];
          end
          `ITDT_T_CNTL: d.tmr[t].cnt_l = bus_i.wdata;
          `ITDT_T_CNTH: d.tmr[t].cnt_h = bus_i.wdata;
          `ITDT_T_RLDL: d.tmr[t].rld_l = bus_i.wdata;
          `ITDT_T_RLDH: d.tmr[t].rld_h = bus_i.wdata;
          default: d.tmr[t].run_l = d.tmr[t].run_l;
        endcase
      end
      d.tmr[t].flag_h = d.tmr[t].flag_h | set_h;
      d.tmr[t].flag_l = d.tmr[t].flag_l | set_l;
      d.irq[t] = q.tmr[t].flag_h | (q.tmr[t].flag_l & q.tmr[t].flag_l_en);
    end

    // Read data stand for exactly one cycle after the strobe.
    d.rdata = `ITDT_RST_VAL;
    if (bus_i.re) begin
      case (bus_i.addr)
        `ITDT_IVL_ADDR:    d.rdata = {q.ivl_flag, q.ivl_en, 3'b000, q.ivl_sel};
        `ITDT_SYSTEM_CLOCK_GENERATOR_REG_ADDR: d.rdata = {5'b00000, q.sys_div};
        `ITDT_CLKSEL_ADDR: d.rdata = q.clksel;
        default: begin
          for (int t = 0; t < 2; t++) begin
            base = (t == 0) ? `ITDT_TMR0_BASE : `ITDT_TMR1_BASE;
            if (bus_i.addr[7:3] == base[7:3]) begin
              case (bus_i.addr[2:0])
                `ITDT_T_CTRL: d.rdata = {q.tmr[t].flag_h, q.tmr[t].flag_l, q.tmr[t].flag_l_en,
                                         q.tmr[t].split, q.tmr[t].cap_h, q.tmr[t].cap_l,
                                         q.tmr[t].run_h, q.tmr[t].run_l};
                `ITDT_T_CNTL: d.rdata = q.tmr[t].cnt_l;
                `ITDT_T_CNTH: d.rdata = q.tmr[t].cnt_h;
                `ITDT_T_RLDL: d.rdata = q.tmr[t].rld_l;
                `ITDT_T_RLDH: d.rdata = q.tmr[t].rld_h;
                default:      d.rdata = `ITDT_RST_VAL;
              endcase
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o    = q.rdata;
  assign tmr_irq_o  = q.irq;
  assign ivl_flag_o = q.ivl_flag;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ivl_clr;
    wr_ivl && bus_i.wdata[`ITDT_IVL_CLR];
  endsequence

  sequence s_wide_wrap0;
    ovh[0] && !q.tmr[0].cap_l && !bus_i.we;
  endsequence

  sequence s_wide_cap0;
    !q.tmr[0].split && q.tmr[0].cap_l && cap_ev_i[0] && !bus_i.we;
  endsequence

  AST_IVL_FLAG_STICKY: assert property (q.ivl_flag && !wr_ivl |=> q.ivl_flag)
    else $error("interval flag dropped without a write");
  AST_IVL_HOLD: assert property (!q.ivl_en && !wr_sys && !wr_ivl |=> $stable(q.tick_cnt) && $stable(q.lo_cnt))
    else $error("interval counters moved while disabled");
  AST_IVL_CLR: assert property (s_ivl_clr ##0 !wr_sys |=> q.lo_cnt == 5'd0 && q.up_cnt == 6'd0
                                && (q.tick_cnt != 8'd0 || $past(q.tick_cnt) == 8'(`ITDT_TICK_CYC - 1)
                                    || !$past(q.ivl_en)))
    else $error("interval clear misbehaved");
  AST_RSVD_ZERO: assert property (bus_i.re && bus_i.addr == `ITDT_IVL_ADDR |=> rdata_o[5:3] == 3'b000)
    else $error("reserved interval bits not zero");
  AST_SHORT_STEP: assert property (tick_stb && q.phase == 2'd3 && q.lo_cnt == 5'd17 && !wr_ivl
                                   |-> p100_stb ##1 q.phase == 2'd0)
    else $error("short step of pulse train wrong");
  AST_SEL0_QUIET: assert property (q.ivl_sel == 3'd0 && !q.ivl_flag && !wr_ivl |=> !q.ivl_flag)
    else $error("flag set with no interval selected");
  AST_IRQ_FORM: assert property (q.tmr[1].flag_h |=> tmr_irq_o[1])
    else $error("high flag did not raise request");
  AST_WIDE_RELOAD: assert property (s_wide_wrap0 |=> {q.tmr[0].cnt_h, q.tmr[0].cnt_l}
                                    == {$past(q.tmr[0].rld_h), $past(q.tmr[0].rld_l)} && q.tmr[0].flag_h)
    else $error("wide reload failed");
  AST_CAPTURE: assert property (s_wide_cap0 |=> {q.tmr[0].rld_h, q.tmr[0].rld_l}
                                == {$past(q.tmr[0].cnt_h), $past(q.tmr[0].cnt_l)} ##0 q.tmr[0].flag_h)
    else $error("capture did not latch count");

endmodule

// *** verif/itdt_top_test.sv ***
`timescale 1ns/1ns

module itdt_top_test;
  import itdt_pkg::*;

  // ==========================================================
  // Stimulus, observation and bookkeeping.
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  itdt_bus_t   bus = '0;
  logic [1:0]  cap_ev = 2'b00;
  logic [7:0]  rdata_o;
  logic [1:0]  tmr_irq_o;
  logic        ivl_flag_o;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          seed = 32'h5636;
  int          t0, t1, td, te, m, n, start;
  logic [7:0]  rv;
  logic [15:0] cnt;
  logic [7:0]  regs [13] = '{8'h9c, 8'h8e, 8'hc9, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac};
  logic [7:0]  src [5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
  logic [7:0]  dv [5] = '{8'h00, 8'h03, 8'h00, 8'h02, 8'h00};
  int          wt [5] = '{98, 398, 598, 1328, 9973};
  int          inc [5] = '{100, 50, 50, 10, 4};

  // The clock toggles every 20 ns; a free count of edges times the flags.
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  itdt_top dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata_o), .cap_ev_i(cap_ev),
                .tmr_irq_o(tmr_irq_o), .ivl_flag_o(ivl_flag_o));

  // ==========================================================
  // Comparisons and bus cycles.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s: %h not %h", $time, msg, got, exp);
    end
  endtask

  // A range is needed where the phase of a free divider is unknown.
  task automatic rng(input logic [15:0] got, input int lo, input int hi, input string msg);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s: %h", $time, msg, got);
    end
  endtask

  // Strobes last one cycle; the edge that takes them also drops them.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge clk_i);
    bus.we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge clk_i);
    bus.re <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, msg);
  endtask

  // Sixteen-bit values go as two bytes; nothing makes them atomic.
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] c);
    rd(a, c[7:0]);
    rd(a + 8'h01, c[15:8]);
  endtask

  task automatic pulse(input logic [1:0] v);
    @(posedge clk_i);
    cap_ev <= v;
    @(posedge clk_i);
    cap_ev <= 2'b00;
  endtask

  // Waits for the interval flag, notes the edge, then writes the control byte.
  task automatic rise(input logic [7:0] ctl, output int t);
    int k;
    k = 0;
    repeat (2) @(posedge clk_i);
    #1;
    while (ivl_flag_o !== 1'b1 && k < 30000) begin
      @(posedge clk_i);
      #1 k++;
    end
    chk(16'(k < 30000), 16'h0001, "flag wait");
    t = cyc;
    wr(8'h9c, ctl);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Test sequence.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) rdc(regs[i], 8'h00, "reset value");
    wr(8'ha5, 8'h5a);
    rdc(8'ha5, 8'h00, "unmapped");
    wr(8'h9c, 8'hff);
    rdc(8'h9c, 8'h47, "interval control");
    $display("test registers done");
    // Selection zero must stay silent for longer than any short interval.
    wr(8'h9c, 8'h40);
    repeat (6000) @(posedge clk_i);
    #1;
    chk(ivl_flag_o, 1'b0, "sel0 flag");
    // Every measured train spans 75 ticks, whatever its phase.
    for (int s = 1; s <= 3; s++) begin
      m = 1 << (s - 1);
      n = (m > 2) ? 1 : 4 / m;
      wr(8'h9c, {5'b01100, 3'(s)});
      rise({5'b01000, 3'(s)}, t0);
      start = t0;
      repeat (n) begin
        rise({5'b01000, 3'(s)}, t1);
        rng(16'(t1 - t0), (75 * m) / 4 * 133, (75 * m + 3) / 4 * 133, "interval");
        t0 = t1;
      end
      chk(16'(t1 - start), 16'd9975, "interval train");
    end
    $display("test intervals done");
    // Writing one to the flag keeps it; only a zero clears it.
    wr(8'h9c, 8'h41);
    rise(8'hc1, t0);
    repeat (300) @(posedge clk_i);
    #1;
    chk(ivl_flag_o, 1'b1, "flag held");
    wr(8'h9c, 8'h01);
    td = cyc;
    repeat (3000) @(posedge clk_i);
    #1;
    chk(ivl_flag_o, 1'b0, "flag while off");
    wr(8'h9c, 8'h41);
    te = cyc;
    rise(8'h41, t1);
    rng(16'(t1 - t0 - (te - td)), 18 * 133 - 2, 19 * 133 + 2, "resume");
    $display("test enable done");
    // Rates of the four sources; the divider must not move the tick.
    for (int i = 0; i < 5; i++) begin
      start = {$random(seed)} % 32'hf000;
      w16(8'ha1, 16'(start));
      wr(8'hc9, src[i]);
      wr(8'h8e, dv[i]);
      wr(8'ha0, 8'h01);
      repeat (wt[i]) @(posedge clk_i);
      wr(8'ha0, 8'h00);
      rd16(8'ha1, cnt);
      rng(cnt - 16'(start), inc[i] - 1, inc[i] + 1, "source rate");
    end
    // A cleared tick generator waits a whole period, so a short run sees no strobe.
    start = cnt;
    wr(8'hc9, 8'h02);
    wr(8'h8e, 8'h08);
    wr(8'ha0, 8'h01);
    repeat (128) @(posedge clk_i);
    wr(8'ha0, 8'h00);
    rd16(8'ha1, cnt);
    chk(cnt, 16'(start), "tick clear");
    // The later scenarios count on the undivided system clock.
    wr(8'hc9, 8'h00);
    $display("test sources done");
    // Wide reload: 22 steps from fff0 wrap once and reload.
    w16(8'ha3, 16'hfff0);
    w16(8'ha1, 16'hfff0);
    wr(8'ha0, 8'h01);
    repeat (20) @(posedge clk_i);
    wr(8'ha0, 8'hc0);
    rd16(8'ha1, cnt);
    chk(cnt, 16'hfff6, "reload count");
    rdc(8'ha0, 8'hc0, "both flags");
    chk(tmr_irq_o, 2'b01, "irq high flag");
    wr(8'ha0, 8'h02);
    repeat (20) @(posedge clk_i);
    rd16(8'ha1, cnt);
    chk(cnt, 16'hfff6, "high run ignored");
    chk(tmr_irq_o, 2'b00, "irq cleared");
    w16(8'ha1, 16'h00f0);
    wr(8'ha0, 8'h01);
    repeat (20) @(posedge clk_i);
    wr(8'ha0, 8'h40);
    rd16(8'ha1, cnt);
    chk(cnt, 16'h0106, "carry");
    rdc(8'ha0, 8'h40, "low flag only");
    chk(tmr_irq_o, 2'b00, "low flag masked");
    wr(8'ha0, 8'h60);
    rdc(8'ha0, 8'h60, "low enable");
    chk(tmr_irq_o, 2'b01, "low flag enabled");
    // Wide capture works while stopped; the other event is not ours.
    wr(8'ha0, 8'h04);
    w16(8'ha1, 16'h1234);
    pulse(2'b10);
    rdc(8'ha0, 8'h04, "foreign event");
    pulse(2'b01);
    rdc(8'ha3, 8'h34, "capture low");
    rdc(8'ha4, 8'h12, "capture high");
    rdc(8'ha0, 8'h84, "capture flag");
    chk(tmr_irq_o, 2'b01, "capture irq");
    w16(8'ha1, 16'hfff0);
    wr(8'ha0, 8'h05);
    repeat (20) @(posedge clk_i);
    wr(8'ha0, 8'h44);
    rd16(8'ha1, cnt);
    chk(cnt, 16'h0006, "free wrap");
    rdc(8'ha0, 8'h44, "wrap flag");
    $display("test wide done");
    // Split: low reloads on the system clock, high captures on a twelfth.
    wr(8'hc9, 8'h40);
    wr(8'hab, 8'hf0);
    w16(8'ha9, 16'h00f0);
    wr(8'ha8, 8'h1b);
    repeat (98) @(posedge clk_i);
    wr(8'ha8, 8'hd8);
    rdc(8'ha9, 8'hf4, "split low");
    rd(8'haa, rv);
    rng(16'(rv), 7, 9, "split high rate");
    rdc(8'ha8, 8'h58, "split flags");
    pulse(2'b10);
    rdc(8'hac, rv, "split capture");
    rdc(8'hab, 8'hf0, "low not captured");
    rdc(8'ha8, 8'hd8, "split capture flag");
    chk(tmr_irq_o, 2'b10, "second timer irq");
    // Reversed roles; the stopping write lands on a high overflow and must lose to it.
    wr(8'hc9, 8'h00);
    wr(8'hac, 8'hf8);
    wr(8'haa, 8'hf8);
    wr(8'ha8, 8'h16);
    repeat (94) @(posedge clk_i);
    wr(8'ha8, 8'h14);
    rdc(8'haa, 8'hf8, "split high reload");
    rdc(8'ha8, 8'h94, "set beats clear");
    pulse(2'b10);
    rdc(8'hab, 8'hf4, "split low capture");
    rdc(8'hac, 8'hf8, "high not captured");
    rdc(8'ha8, 8'hd4, "both split flags");
    chk(tmr_irq_o, 2'b10, "reversed irq");
    $display("test split done");
    report_and_stop;
  end

  // A hang is cut short well after the expected run of about 75000 cycles.
  initial begin
    #(40 * 100000);
    fail_count++;
    report_and_stop;
  end

endmodule
